// >>> inc/tam_pkg.sv
// constants and types for the test access mode control block
package tam_pkg;
  typedef enum logic [1:0] {
    TAM_USER_NONE = 2'b00,
    TAM_USER_CRAFT = 2'b01,
    TAM_USER_TL1 = 2'b10,
    TAM_USER_EM = 2'b11
  } tam_user_t;

  typedef enum logic [1:0] {
    TAM_LC_INTERNAL = 2'b00,
    TAM_LC_AMI = 2'b01,
    TAM_LC_B8ZS = 2'b10
  } tam_code_t;

  typedef enum logic [3:0] {
    TAM_MODE_DISABLE = 4'b0000,
    TAM_MODE_MON_A = 4'b0001,
    TAM_MODE_MON_B = 4'b0010,
    TAM_MODE_SPLIT_A = 4'b0011,
    TAM_MODE_SPLIT_B = 4'b0100,
    TAM_MODE_SPLIT_E = 4'b0101,
    TAM_MODE_SPLIT_F = 4'b0110,
    TAM_MODE_SPLIT_EL = 4'b0111,
    TAM_MODE_SPLIT_FL = 4'b1000,
    TAM_MODE_LOOP_E = 4'b1001,
    TAM_MODE_LOOP_F = 4'b1010
  } tam_mode_t;

  typedef enum logic [1:0] {
    TAM_PAT_QUASI_RANDOM = 2'b00,
    TAM_PAT_OTHER = 2'b01
  } tam_pat_t;

  localparam logic [2:0] TAM_GROUP_MIN = 3'h1;
  localparam logic [2:0] TAM_GROUP_MAX = 3'h7;
  localparam logic [2:0] TAM_SLOT_MIN = 3'h1;
  localparam logic [2:0] TAM_SLOT_MAX = 3'h4;
  localparam logic [2:0] TAM_GROUP_RESET = 3'h1;
  localparam logic [2:0] TAM_SLOT_RESET = 3'h1;
  localparam logic [4:0] TAM_ACC_NONE = 5'h00;
endpackage

// >>> src/tam_cmd_pulse.sv
// one-cycle drop and insert command register
`timescale 1ns/1ns
module tam_cmd_pulse (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  output logic pulse
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse <= 1'b0;
    end else begin
      pulse <= fire;
    end
  end
endmodule

// >>> src/tam_access_ctrl.sv
// test access mode control and interlock logic
`timescale 1ns/1ns
// How it works
// - a tl1 connect request sets the controlling user to tl1 by itself.
// - a local terminal write of tl1 as controlling user is rejected.
// - the controlling user may also be the element manager.
// - line code is internal, ami or b8zs and resets to internal.
// - internal line code disables the front jacks and selects generator and detector.
// - an intrusive mode with internal line code forces the quasi-random unframed pattern.
// - the test circuit is group 1 to 7 and slot 1 to 4, resetting to 1-1.
// - the test circuit changes only while the mode is disabled.
// - a committed mode change commands the mux to drop and insert; mode resets to disabled.
// - disabled mode gives neither monitor nor split access.
// - writing disabled stops any running measurement like a stop command.
// - entering disabled restores the circuit to its normal path.
// - monitor-a attaches the detector to the a pair without breaking it.
// - monitor-b attaches the detector to the b pair without breaking it.
// - a controlling user of none forces the mode to disabled.
module tam_access_ctrl
  import tam_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tl1Connect,
  input wire logic userWrite,
  input wire logic [1:0] userWriteData,
  input wire logic emWrite,
  input wire logic codeWrite,
  input wire logic [1:0] codeWriteData,
  input wire logic circuitWrite,
  input wire logic [2:0] circuitGroupIn,
  input wire logic [2:0] circuitSlotIn,
  input wire logic modeWrite,
  input wire logic [3:0] modeWriteData,
  input wire logic measStart,
  input wire logic measStop,
  output logic [1:0] currentUser,
  output logic [1:0] lineCode,
  output logic [2:0] circuitGroup,
  output logic [2:0] circuitSlot,
  output logic [3:0] accessMode,
  output logic dropInsertCmd,
  output logic frontJacksEnable,
  output logic internalTestSel,
  output logic [1:0] patternType,
  output logic patternUnframed,
  output logic measRunning,
  output logic monitorAttachA,
  output logic monitorAttachB,
  output logic splitActive,
  output logic normalPath,
  output logic tl1Rejected
);
  // current state registers
  tam_user_t user;
  tam_code_t code;
  tam_mode_t mode;
  tam_pat_t pat;

  function automatic logic modeDefined(input logic [3:0] m);
    modeDefined = (m <= TAM_MODE_LOOP_F);
  endfunction

  function automatic logic isIntrusive(input tam_mode_t m);
    isIntrusive = (m != TAM_MODE_DISABLE) && (m != TAM_MODE_MON_A) && (m != TAM_MODE_MON_B);
  endfunction

  function automatic logic inRange(input logic [2:0] v, input logic [2:0] lo,
                                   input logic [2:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction

  // decode of writes
  wire logic craftTl1Try = userWrite && (userWriteData == TAM_USER_TL1);
  wire logic userOk = userWrite && !craftTl1Try;
  wire logic modeOk = modeWrite && modeDefined(modeWriteData);
  wire logic codeOk = codeWrite && (codeWriteData != 2'b11);
  wire logic grpOk = inRange(circuitGroupIn, TAM_GROUP_MIN, TAM_GROUP_MAX);
  wire logic slotOk = inRange(circuitSlotIn, TAM_SLOT_MIN, TAM_SLOT_MAX);
  wire logic circuitOk = circuitWrite && grpOk && slotOk && (mode == TAM_MODE_DISABLE);

  // next user
  tam_user_t next_user;
  always_comb begin
    next_user = user;
    if (userOk) begin
      next_user = tam_user_t'(userWriteData);
    end
    if (emWrite) begin
      next_user = TAM_USER_EM;
    end
    if (tl1Connect) begin
      next_user = TAM_USER_TL1;
    end
  end

  // next mode
  tam_mode_t next_mode;
  always_comb begin
    next_mode = mode;
    if (modeOk) begin
      next_mode = tam_mode_t'(modeWriteData);
    end
    if (next_user == TAM_USER_NONE) begin
      next_mode = TAM_MODE_DISABLE;
    end
  end

  // derived next values
  wire logic modeChange = (next_mode != mode);
  wire logic stopNow = measStop || (modeOk && (modeWriteData == TAM_MODE_DISABLE));
  wire logic intrusiveInt = isIntrusive(next_mode) && (code == TAM_LC_INTERNAL);
  wire logic startOk = measStart && (next_mode != TAM_MODE_DISABLE);
  wire logic next_jacks = codeOk ? (codeWriteData != TAM_LC_INTERNAL)
                                 : (code != TAM_LC_INTERNAL);
  wire logic next_internal = !next_jacks;
  wire logic next_attachA = (next_mode == TAM_MODE_MON_A);
  wire logic next_attachB = (next_mode == TAM_MODE_MON_B);
  wire logic next_split = isIntrusive(next_mode);

  logic modeChanged;

  // user, mode and command stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      user <= TAM_USER_NONE;
      mode <= TAM_MODE_DISABLE;
      modeChanged <= 1'b0;
      tl1Rejected <= 1'b0;
    end else begin
      user <= next_user;
      mode <= next_mode;
      modeChanged <= modeChange;
      tl1Rejected <= craftTl1Try;
    end
  end

  // line code
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code <= TAM_LC_INTERNAL;
    end else if (codeOk) begin
      code <= tam_code_t'(codeWriteData);
    end
  end

  // test circuit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      circuitGroup <= TAM_GROUP_RESET;
      circuitSlot <= TAM_SLOT_RESET;
    end else if (circuitOk) begin
      circuitGroup <= circuitGroupIn;
      circuitSlot <= circuitSlotIn;
    end
  end

  // generator pattern
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pat <= TAM_PAT_QUASI_RANDOM;
      patternUnframed <= 1'b1;
    end else if (modeChange && intrusiveInt) begin
      pat <= TAM_PAT_QUASI_RANDOM;
      patternUnframed <= 1'b1;
    end
  end

  // measurement
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      measRunning <= 1'b0;
    end else if (stopNow) begin
      measRunning <= 1'b0;
    end else if (startOk) begin
      measRunning <= 1'b1;
    end
  end

  // line code paths
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frontJacksEnable <= 1'b0;
      internalTestSel <= 1'b1;
    end else begin
      frontJacksEnable <= next_jacks;
      internalTestSel <= next_internal;
    end
  end

  // access paths
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      monitorAttachA <= 1'b0;
      monitorAttachB <= 1'b0;
      splitActive <= 1'b0;
      normalPath <= 1'b1;
    end else begin
      monitorAttachA <= next_attachA;
      monitorAttachB <= next_attachB;
      splitActive <= next_split;
      normalPath <= !next_split;
    end
  end

  assign currentUser = user;
  assign lineCode = code;
  assign accessMode = mode;
  assign patternType = pat;

  tam_cmd_pulse u_cmd (
    .clk(clk),
    .rst_n(rst_n),
    .fire(modeChanged),
    .pulse(dropInsertCmd)
  );
endmodule

// >>> tb/tam_mux_model.sv
// multiplexer model counting drop and insert commands
`timescale 1ns/1ns
module tam_mux_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dropInsertCmd,
  output logic [7:0] dropCount
);
  always_ff @(posedge clk) begin
    if (!rst_n) dropCount <= 8'h00;
    else if (dropInsertCmd) dropCount <= dropCount + 8'h01;
  end
endmodule

// >>> tb/tam_access_monitor.sv
// assertions on the access mode control ports
`timescale 1ns/1ns
module tam_access_monitor
  import tam_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tl1Connect,
  input wire logic userWrite,
  input wire logic circuitWrite,
  input wire logic modeWrite,
  input wire logic [3:0] modeWriteData,
  input wire logic [1:0] currentUser,
  input wire logic [2:0] circuitGroup,
  input wire logic [3:0] accessMode,
  input wire logic dropInsertCmd,
  input wire logic monitorAttachA,
  input wire logic monitorAttachB,
  input wire logic splitActive,
  input wire logic normalPath
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_drop; $changed(accessMode) |=> dropInsertCmd; endproperty
  a_drop: assert property (p_drop) else $error("drop");
  property p_dis;
    accessMode == 4'h0 |-> !splitActive && !monitorAttachA && !monitorAttachB && normalPath;
  endproperty
  a_dis: assert property (p_dis) else $error("dis");
  property p_mona; accessMode == 4'h1 |-> monitorAttachA && normalPath; endproperty
  a_mona: assert property (p_mona) else $error("mona");
  property p_monb; accessMode == 4'h2 |-> monitorAttachB && normalPath; endproperty
  a_monb: assert property (p_monb) else $error("monb");
  property p_none; currentUser == 2'h0 |-> accessMode == 4'h0; endproperty
  a_none: assert property (p_none) else $error("none");
  property p_tl1; tl1Connect |=> currentUser == 2'h2; endproperty
  a_tl1: assert property (p_tl1) else $error("tl1");
  property p_circ; circuitWrite && accessMode != 4'h0 |=> $stable(circuitGroup); endproperty
  a_circ: assert property (p_circ) else $error("circ");
  property p_inv; modeWrite && modeWriteData > 4'hA && !userWrite |=> $stable(accessMode);
  endproperty
  a_inv: assert property (p_inv) else $error("inv");
endmodule
bind tam_access_ctrl tam_access_monitor u_mon (.*);

// >>> tb/testbench.sv
// bench for the access mode control block
`timescale 1ns/1ns
module testbench;
  logic clk, rst_n, tl1Connect, userWrite, emWrite, codeWrite, circuitWrite, modeWrite;
  logic measStart, measStop, dropInsertCmd, frontJacksEnable, internalTestSel;
  logic patternUnframed, measRunning, monitorAttachA, monitorAttachB, splitActive;
  logic normalPath, tl1Rejected;
  logic [1:0] userWriteData, codeWriteData, currentUser, lineCode, patternType;
  logic [2:0] circuitGroupIn, circuitSlotIn, circuitGroup, circuitSlot;
  logic [3:0] modeWriteData, accessMode;
  logic [7:0] dropCount;
  int nFail = 0;
  int checked = 0;
  tam_access_ctrl u_dut (.*);
  tam_mux_model u_mux (.*);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go;
    @(negedge clk);
    {tl1Connect, userWrite, emWrite, codeWrite, circuitWrite, modeWrite, measStart} = '0;
  endtask
  task automatic giveVerdict;
    if (nFail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst_n, measStop, userWriteData, codeWriteData, circuitGroupIn, circuitSlotIn} = '0;
    {modeWriteData, tl1Connect, userWrite, emWrite, codeWrite, circuitWrite} = '0;
    {modeWrite, measStart} = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    chk({circuitGroup, circuitSlot, lineCode}, 8'h24, "rst");
    userWrite = 1'h1;
    userWriteData = 2'h2;
    go;
    chk({currentUser, tl1Rejected}, 8'h01, "rej");
    emWrite = 1'h1;
    go;
    chk(currentUser, 8'h03, "em");
    tl1Connect = 1'h1;
    codeWrite = 1'h1;
    codeWriteData = 2'h3;
    go;
    codeWrite = 1'h1;
    codeWriteData = 2'h2;
    repeat (2) go;
    chk({lineCode, frontJacksEnable}, 8'h05, "code");
    codeWrite = 1'h1;
    codeWriteData = 2'h0;
    repeat (2) go;
    chk({frontJacksEnable, internalTestSel}, 8'h01, "int");
    circuitWrite = 1'h1;
    {circuitGroupIn, circuitSlotIn} = 6'h3C;
    go;
    chk({circuitGroup, circuitSlot}, 8'h3C, "tc");
    for (int m = 10; m >= 1; m--) begin
      modeWrite = 1'h1;
      modeWriteData = 4'(m);
      repeat (2) go;
      chk({accessMode, dropInsertCmd}, 8'(m * 2 + 1), "mode");
    end
    {circuitWrite, modeWrite, measStart} = 3'h7;
    modeWriteData = 4'hF;
    go;
    chk(accessMode, 8'h01, "inv");
    chk({splitActive, monitorAttachA, monitorAttachB, patternType, patternUnframed}, 8'h11, "pth");
    modeWrite = 1'h1;
    modeWriteData = 4'h0;
    go;
    chk({measRunning, normalPath}, 8'h01, "stop");
    modeWrite = 1'h1;
    modeWriteData = 4'h1;
    go;
    userWrite = 1'h1;
    userWriteData = 2'h0;
    repeat (3) go;
    chk(dropCount, 8'h0D, "cnt");
    giveVerdict;
  end
endmodule
